/* File: hdl/dlc_defs.vh */
// Constants for the converter load-control block
`ifndef DLC_DEFS_VH
`define DLC_DEFS_VH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define DLC_ADDR_W      8
`define DLC_OFF_CTRL    8'h00
`define DLC_OFF_PWR     8'h04
`define DLC_OFF_STAGE   8'h08
`define DLC_OFF_HOLD    8'h0C
`define DLC_OFF_STAT    8'h10
`define DLC_OFF_PORT    8'h14
// ----------------------------------------------------------------
// Load select codes
// ----------------------------------------------------------------
`define DLC_LS_RISE     3'h0
`define DLC_LS_SW       3'h1
`define DLC_LS_NONE     3'h2
`define DLC_LS_SW_ALIAS 3'h3
`define DLC_LS_FALL     3'h4
`define DLC_LS_SQUARE   3'h5
`define DLC_LS_RISE_A6  3'h6
`define DLC_LS_RISE_A7  3'h7
// Effective modes after aliasing
`define DLC_M_RISE      3'h0
`define DLC_M_SW        3'h1
`define DLC_M_NONE      3'h2
`define DLC_M_FALL      3'h3
`define DLC_M_SQUARE    3'h4
// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define DLC_LS_MSB      2
`define DLC_PWR_BIT     0
`define DLC_PORT_DIR    0
`define DLC_PORT_OUT    1
`define DLC_PORT_PU     2
`define DLC_LS_RST      3'h2
`define DLC_PORT_RST    3'h4
`define DLC_DATA_RST    12'h000
`endif

/* File: hdl/dlc_load_control.v */
// Converter load control with APB registers and shared strobe pin
//
// Behaviour
// - Select 000: strobe rising edge copies staging into hold and converts.
// - Select 100: strobe falling edge copies staging into hold and converts.
// - Edge load codes turn the shared pin into the strobe input.
// - Select 001: each staging write copies the new value into hold.
// - Code 011 behaves like 001.
// - Codes 110 and 111 behave like 000.
// - Square mode: falling edge shows staging, rising edge shows hold.
// - Square mode: only edges after mode entry change the source.
// - Outside square mode converter input follows hold at once.
// - Power enable clear: converter off, no conversion in any mode.
// - Staging and hold keep taking writes and loads while powered down.
// - Hold is 12 bits, normal source; staging a source in square mode.
// - After reset the pin is general I/O with pull-up on.
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "dlc_defs.vh"

module dlc_load_control #(
  parameter DATA_W = 12
) (
  input  wire                     clock_i,
  input  wire                     rst_i,
  // APB slave
  input  wire                     psel_i,
  input  wire                     penable_i,
  input  wire                     pwrite_i,
  input  wire [`DLC_ADDR_W-1:0]   paddr_i,
  input  wire [31:0]              pwdata_i,
  output reg  [31:0]              prdata_o,
  output wire                     pready_o,
  output wire                     pslverr_o,
  // Shared port pin
  input  wire                     shared_port_pin_i,
  output reg                      shared_port_pin_o,
  output reg                      shared_port_pin_oe_o,
  output reg                      shared_port_pin_pullup_o,
  // Converter side
  output reg  [DATA_W-1:0]        conv_data_o,
  output reg                      conv_enable_o,
  output reg                      conv_start_o
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Fold reserved codes onto the mode they alias
  function [2:0] eff_mode;
    input [2:0] sel;
    begin
      case (sel)
        `DLC_LS_RISE:     eff_mode = `DLC_M_RISE;
        `DLC_LS_RISE_A6:  eff_mode = `DLC_M_RISE;
        `DLC_LS_RISE_A7:  eff_mode = `DLC_M_RISE;
        `DLC_LS_SW:       eff_mode = `DLC_M_SW;
        `DLC_LS_SW_ALIAS: eff_mode = `DLC_M_SW;
        `DLC_LS_FALL:     eff_mode = `DLC_M_FALL;
        `DLC_LS_SQUARE:   eff_mode = `DLC_M_SQUARE;
        default:          eff_mode = `DLC_M_NONE;
      endcase
    end
  endfunction

  // Address is one of the mapped words
  function mapped;
    input [`DLC_ADDR_W-1:0] a;
    begin
      mapped = (a == `DLC_OFF_CTRL) || (a == `DLC_OFF_PWR) ||
               (a == `DLC_OFF_STAGE) || (a == `DLC_OFF_HOLD) ||
               (a == `DLC_OFF_STAT) || (a == `DLC_OFF_PORT);
    end
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg  [2:0]        load_select;
  reg               converter_power_enable;
  reg  [DATA_W-1:0] input_staging_register;
  reg  [DATA_W-1:0] output_hold_register;
  reg  [2:0]        port_ctrl;
  reg               strobe_meta;
  reg               strobe_sync;
  reg               strobe_last;
  reg               square_armed;
  reg               square_show_stage;
  reg  [DATA_W-1:0] next_hold;
  reg               next_show_stage;
  reg               load_now;
  reg  [31:0]       rdata;

  wire [2:0] mode     = eff_mode(load_select);
  wire       strobe_fn = (mode == `DLC_M_RISE) ||
                         (mode == `DLC_M_FALL) ||
                         (mode == `DLC_M_SQUARE);
  wire       acc      = psel_i & penable_i;
  wire       hit      = mapped(paddr_i);
  wire       wr       = acc & pwrite_i & hit;
  wire       wr_stage = wr & (paddr_i == `DLC_OFF_STAGE);
  wire       wr_hold  = wr & (paddr_i == `DLC_OFF_HOLD);
  // Edges only from synchronised samples, gated off while pin is GPIO
  wire       rise     = strobe_fn & strobe_sync & ~strobe_last;
  wire       fall     = strobe_fn & ~strobe_sync & strobe_last;

  // Zero wait state; unmapped words answer with an error
  assign pready_o  = 1'b1;
  assign pslverr_o = acc & ~hit;

  // ----------------------------------------------------------------
  // Strobe synchroniser
  // ----------------------------------------------------------------

  // Two flops before the edge detector sees the pin
  // Reset to the pulled-up idle level, so no false edge follows reset
  always @(posedge clock_i) begin
    if (rst_i) begin
      strobe_meta <= 1'b1;
      strobe_sync <= 1'b1;
      strobe_last <= 1'b1;
    end else begin
      strobe_meta <= shared_port_pin_i;
      strobe_sync <= strobe_meta;
      strobe_last <= strobe_sync;
    end
  end

  // ----------------------------------------------------------------
  // Load decision
  // ----------------------------------------------------------------

  // Loads ignore power so a value can be staged while off
  always @* begin
    next_hold = output_hold_register;
    load_now  = 1'b0;
    case (mode)
      `DLC_M_RISE: begin
        if (rise) begin
          next_hold = input_staging_register;
          load_now  = 1'b1;
        end
      end
      `DLC_M_FALL: begin
        if (fall) begin
          next_hold = input_staging_register;
          load_now  = 1'b1;
        end
      end
      `DLC_M_SW: begin
        if (wr_stage) begin
          next_hold = pwdata_i[DATA_W-1:0];
          load_now  = 1'b1;
        end
      end
      default: begin
        next_hold = output_hold_register;
        load_now  = 1'b0;
      end
    endcase
    // Direct hold write, used to seed square mode
    if (wr_hold) begin
      next_hold = pwdata_i[DATA_W-1:0];
    end
  end

  // Square mode source choice; edges count only once armed
  always @* begin
    next_show_stage = square_show_stage;
    if (mode != `DLC_M_SQUARE) begin
      next_show_stage = 1'b0;
    end else if (square_armed & fall) begin
      next_show_stage = 1'b1;
    end else if (square_armed & rise) begin
      next_show_stage = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------

  // Register writes and loads, valid in power-down too
  always @(posedge clock_i) begin
    if (rst_i) begin
      load_select            <= `DLC_LS_RST;
      converter_power_enable <= 1'b0;
      input_staging_register <= `DLC_DATA_RST;
      output_hold_register   <= `DLC_DATA_RST;
      port_ctrl              <= `DLC_PORT_RST;
    end else begin
      if (wr & (paddr_i == `DLC_OFF_CTRL)) begin
        load_select <= pwdata_i[`DLC_LS_MSB:0];
      end
      if (wr & (paddr_i == `DLC_OFF_PWR)) begin
        converter_power_enable <= pwdata_i[`DLC_PWR_BIT];
      end
      if (wr & (paddr_i == `DLC_OFF_PORT)) begin
        port_ctrl <= pwdata_i[`DLC_PORT_PU:0];
      end
      if (wr_stage) begin
        input_staging_register <= pwdata_i[DATA_W-1:0];
      end
      output_hold_register <= next_hold;
    end
  end

  // Arming waits one cycle so an entry-cycle edge is dropped
  always @(posedge clock_i) begin
    if (rst_i) begin
      square_armed      <= 1'b0;
      square_show_stage <= 1'b0;
    end else begin
      square_armed      <= (mode == `DLC_M_SQUARE);
      square_show_stage <= next_show_stage;
    end
  end

  // ----------------------------------------------------------------
  // Converter side
  // ----------------------------------------------------------------

  // Data follows the new hold in the same edge it is loaded
  always @(posedge clock_i) begin
    if (rst_i) begin
      conv_data_o   <= `DLC_DATA_RST;
      conv_enable_o <= 1'b0;
      conv_start_o  <= 1'b0;
    end else begin
      if (next_show_stage) begin
        conv_data_o <= input_staging_register;
      end else begin
        conv_data_o <= next_hold;
      end
      conv_enable_o <= converter_power_enable;
      // A square-mode edge also retriggers the converter
      conv_start_o  <= converter_power_enable &
                       (load_now | (next_show_stage != square_show_stage));
    end
  end

  // ----------------------------------------------------------------
  // Shared pin
  // ----------------------------------------------------------------

  // Strobe function forces the driver off whatever the direction bit
  always @(posedge clock_i) begin
    if (rst_i) begin
      shared_port_pin_o        <= 1'b0;
      shared_port_pin_oe_o     <= 1'b0;
      shared_port_pin_pullup_o <= 1'b1;
    end else begin
      shared_port_pin_o        <= port_ctrl[`DLC_PORT_OUT];
      shared_port_pin_oe_o     <= port_ctrl[`DLC_PORT_DIR] & ~strobe_fn;
      shared_port_pin_pullup_o <= port_ctrl[`DLC_PORT_PU];
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------

  // Read mux; unused upper bits read as zero
  always @* begin
    rdata = 32'h0000_0000;
    case (paddr_i)
      `DLC_OFF_CTRL:  rdata[`DLC_LS_MSB:0] = load_select;
      `DLC_OFF_PWR:   rdata[`DLC_PWR_BIT]  = converter_power_enable;
      `DLC_OFF_STAGE: rdata[DATA_W-1:0]    = input_staging_register;
      `DLC_OFF_HOLD:  rdata[DATA_W-1:0]    = output_hold_register;
      `DLC_OFF_STAT: begin
        rdata[DATA_W-1:0] = conv_data_o;
        rdata[DATA_W]     = square_show_stage;
        rdata[DATA_W+1]   = strobe_fn;
        rdata[DATA_W+2]   = strobe_sync;
      end
      `DLC_OFF_PORT:  rdata[`DLC_PORT_PU:0] = port_ctrl;
      default:        rdata = 32'h0000_0000;
    endcase
  end

  // Captured in the setup cycle, shown through the access phase
  always @(posedge clock_i) begin
    if (rst_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (psel_i & ~penable_i & ~pwrite_i) begin
      prdata_o <= rdata;
    end
  end

endmodule
`default_nettype wire

/* File: verification/dlc_assertions.sv */
// Checker for the converter load-control block
`timescale 1ns/1ps
`default_nettype none
module dlc_checker (
  input wire logic        clock_i,
  input wire logic        rst_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        shared_port_pin_i,
  input wire logic        shared_port_pin_o,
  input wire logic        shared_port_pin_oe_o,
  input wire logic        shared_port_pin_pullup_o,
  input wire logic [11:0] conv_data_o,
  input wire logic        conv_enable_o,
  input wire logic        conv_start_o
);
  // ----------------------------------------
  // Shadow of the registers and pin samples
  // ----------------------------------------
  logic [2:0]  ls;
  logic        pwr;
  logic [11:0] stg;
  logic [11:0] hld;
  logic [2:0]  sy;
  wire         wr = psel_i && penable_i && pwrite_i;
  wire         edg = ls == 3'h0 || ls == 3'h4 || ls >= 3'h6;
  wire         rise = sy[1] && !sy[2];
  wire         fall = !sy[1] && sy[2];
  // Same three-stage delay as the pin synchroniser, so edges line up
  always @(posedge clock_i) begin
    sy <= rst_i ? {3{shared_port_pin_i}} : {sy[1:0], shared_port_pin_i};
    if (rst_i) begin
      ls <= 3'h2;
      pwr <= 1'b0;
      stg <= 12'h000;
      hld <= 12'h000;
    end else begin
      if (wr && paddr_i == 8'h00) ls <= pwdata_i[2:0];
      if (wr && paddr_i == 8'h04) pwr <= pwdata_i[0];
      if (wr && paddr_i == 8'h08) stg <= pwdata_i[11:0];
      // Hold also takes edge and software loads; a direct write wins
      if (wr && paddr_i == 8'h0C) hld <= pwdata_i[11:0];
      else if (wr && paddr_i == 8'h08 && (ls == 3'h1 || ls == 3'h3)) hld <= pwdata_i[11:0];
      else if (((ls == 3'h0 || ls >= 3'h6) && rise) || (ls == 3'h4 && fall)) hld <= stg;
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  rise_load_a: assert property ((ls == 3'h0 || ls >= 3'h6) && rise && !wr
    |=> conv_data_o == $past(stg)) else $error("rising edge load wrong");
  fall_load_a: assert property (ls == 3'h4 && fall && !wr
    |=> conv_data_o == $past(stg)) else $error("falling edge load wrong");
  sw_load_a: assert property (wr && paddr_i == 8'h08 && (ls == 3'h1 || ls == 3'h3)
    |=> conv_data_o == $past(pwdata_i[11:0])) else $error("software load wrong");
  no_load_a: assert property (ls == 3'h2 && $past(ls) == 3'h2 && !wr |=> $stable(conv_data_o))
    else $error("load in idle code");
  sq_fall_a: assert property (ls == 3'h5 && $past(ls) == 3'h5 && fall && !wr
    |=> conv_data_o == $past(stg)) else $error("square falling source wrong");
  sq_rise_a: assert property (ls == 3'h5 && $past(ls) == 3'h5 && rise && !wr
    |=> conv_data_o == $past(hld)) else $error("square rising source wrong");
  start_off_a: assert property (!pwr && !$past(pwr) |-> !conv_start_o)
    else $error("conversion while powered down");
  pin_strobe_a: assert property (edg && $past(edg) |-> !shared_port_pin_oe_o)
    else $error("pin driven in strobe mode");
  unmapped_a: assert property (psel_i && penable_i && paddr_i > 8'h14 |-> pslverr_o && pready_o)
    else $error("unmapped access not refused");
  reset_pin_a: assert property ($fell(rst_i) |-> shared_port_pin_pullup_o && !shared_port_pin_oe_o)
    else $error("pin not general I/O after reset");
  cover property (ls == 3'h0 && rise);
  cover property (ls == 3'h5 && fall);
  cover property (pslverr_o);
endmodule
bind dlc_load_control dlc_checker i_chk (.clock_i(clock_i), .rst_i(rst_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .shared_port_pin_i(shared_port_pin_i), .shared_port_pin_o(shared_port_pin_o),
  .shared_port_pin_oe_o(shared_port_pin_oe_o), .shared_port_pin_pullup_o(shared_port_pin_pullup_o),
  .conv_data_o(conv_data_o), .conv_enable_o(conv_enable_o), .conv_start_o(conv_start_o));
`default_nettype wire

/* File: verification/dlc_strobe_src.sv */
// Behavioural source of the external load strobe
`timescale 1ns/1ps
`default_nettype none
module dlc_strobe_src (
  input  wire logic clock_i,
  output var logic  level_o,
  output var logic  drive_o
);
  // Released at start, so the pin rests on its pull-up
  initial begin
    level_o = 1'b1;
    drive_o = 1'b0;
  end
  // Move the strobe, then keep it; a level held for one clock is already caught by the synchroniser
  task automatic move(input logic lvl, input int hold);
    @(posedge clock_i);
    level_o <= lvl;
    drive_o <= 1'b1;
    repeat (hold) @(posedge clock_i);
  endtask
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
// Self-checking bench for the converter load-control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clock_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  wire  [31:0] prdata;
  wire  [11:0] c_data;
  wire         pready, pslverr, pin_o, pin_oe, pin_pu, c_en, c_start, s_lvl, s_drv, pin_w;
  logic [31:0] seed = 32'h3;
  logic [31:0] q, d;
  logic [11:0] cur;
  logic        err, t;
  logic [2:0]  ecode [4] = '{3'h0, 3'h6, 3'h7, 3'h4};
  logic [2:0]  scode [3] = '{3'h1, 3'h3, 3'h2};
  int          failures = 0;
  int          num_checks = 0;
  int          starts = 0;
  int          k;
  dlc_load_control i_dlc_load_control (.clock_i(clock_i), .rst_i(rst_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .shared_port_pin_i(pin_w),
    .shared_port_pin_o(pin_o), .shared_port_pin_oe_o(pin_oe), .shared_port_pin_pullup_o(pin_pu),
    .conv_data_o(c_data), .conv_enable_o(c_en), .conv_start_o(c_start));
  dlc_strobe_src i_dlc_strobe_src (.clock_i(clock_i), .level_o(s_lvl), .drive_o(s_drv));
  // Undriven pin falls to its pull-up, else to the opposite of the source level
  assign pin_w = pin_oe ? pin_o : s_drv ? s_lvl : pin_pu ? 1'b1 : ~s_lvl;
  always #10 clock_i = ~clock_i;
  // Count conversion pulses
  always @(posedge clock_i) if (c_start === 1'b1) starts <= starts + 1;
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Which strobe level triggers a load for an edge code
  function automatic logic trig(input logic [2:0] c);
    return c != 3'h4;
  endfunction
  // One APB transfer; waits for pready, takes data at that edge only
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clock_i);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= wd;
    @(posedge clock_i);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never gets an answer
    do @(posedge clock_i); while (pready !== 1'b1);
    q = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("Checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clock_i);
    failures++;
    tally_and_finish();
  end
  // Main sequence; outputs other than pin_pu and the APB results are compared at falling edges, where they are settled
  initial begin
    repeat (12) @(posedge clock_i);
    rst_i <= 1'b0;
    apb(1'b0, 8'h00, 32'h0); chk(q, 32'h2);
    chk(32'(pin_pu), 32'h1);
    // Pin driven high as an output, then the strobe function takes it over
    apb(1'b1, 8'h14, 32'h7); repeat (2) @(negedge clock_i);
    chk(32'(pin_oe), 32'h1); chk(32'(pin_o), 32'h1);
    apb(1'b1, 8'h00, 32'h0); repeat (2) @(negedge clock_i);
    chk(32'(pin_oe), 32'h0);
    apb(1'b1, 8'h14, 32'h4);
    apb(1'b1, 8'h04, 32'h1);
    $display("Test reset done");
    cur = 12'h000;
    foreach (ecode[i]) begin
      t = trig(ecode[i]);
      apb(1'b1, 8'h00, 32'(ecode[i]));
      i_dlc_strobe_src.move(~t, 3);
      d = rnd(); apb(1'b1, 8'h08, d);
      k = starts;
      i_dlc_strobe_src.move(t, 2 + rnd() % 4);
      repeat (3) @(negedge clock_i);
      chk(32'(c_data), 32'(d[11:0])); chk(32'(starts - k), 32'h1);
      chk(32'(pin_oe), 32'h0);
      apb(1'b1, 8'h08, rnd()); i_dlc_strobe_src.move(~t, 3);
      repeat (3) @(negedge clock_i);
      chk(32'(c_data), 32'(d[11:0]));
      cur = d[11:0];
    end
    $display("Test edge loads done");
    foreach (scode[i]) begin
      apb(1'b1, 8'h00, 32'(scode[i]));
      d = rnd(); k = starts; apb(1'b1, 8'h08, d);
      i_dlc_strobe_src.move(~s_lvl, 3);
      repeat (3) @(negedge clock_i);
      if (scode[i] != 3'h2) cur = d[11:0];
      chk(32'(c_data), 32'(cur)); chk(32'(starts - k), scode[i] != 3'h2);
    end
    $display("Test software loads done");
    i_dlc_strobe_src.move(1'b1, 3);
    d = rnd(); apb(1'b1, 8'h0C, d); apb(1'b1, 8'h08, ~d);
    apb(1'b1, 8'h00, 32'h5); repeat (2) @(negedge clock_i);
    chk(32'(c_data), 32'(d[11:0]));
    cur = ~d[11:0];
    i_dlc_strobe_src.move(1'b0, 3); repeat (3) @(negedge clock_i);
    chk(32'(c_data), 32'(cur));
    // Status: synced pin low, strobe function on, staging shown
    apb(1'b0, 8'h10, 32'h0); chk(q, {17'h0, 3'h3, cur});
    i_dlc_strobe_src.move(1'b1, 3); repeat (3) @(negedge clock_i);
    chk(32'(c_data), 32'(d[11:0]));
    $display("Test square wave done");
    apb(1'b1, 8'h00, 32'h1); apb(1'b1, 8'h04, 32'h0);
    d = rnd(); k = starts; apb(1'b1, 8'h08, d); repeat (3) @(negedge clock_i);
    chk(32'(c_data), 32'(d[11:0])); chk(32'(starts - k), 32'h0);
    chk(32'(c_en), 32'h0);
    apb(1'b0, 8'h0C, 32'h0); chk(q, 32'(d[11:0]));
    apb(1'b1, 8'h04, 32'h1);
    $display("Test power down done");
    apb(1'b0, 8'h40, 32'h0); chk(32'(err), 32'h1); chk(q, 32'h0);
    $display("Test unmapped done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
